// File: clock_reset_power_supervisor.sv
// clock source selection, reset delay, watchdog and power mode supervisor
`timescale 1ns/1ns
`default_nettype none
module clock_reset_power_supervisor
   import clk_sup_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] clock_select_fuses,
   input  wire logic       wdt_fuse_on,
   input  wire logic       ext_reset_req,
   input  wire logic       primary_osc_tick,
   input  wire logic       primary_ready,
   input  wire logic       pll_locked,
   input  wire logic       low_power_rc_clock_tick,
   input  wire logic       wdt_clear,
   input  wire logic       sleep_req,
   input  wire logic       idle_req,
   input  wire logic       irq_pending,
   input  wire logic [7:0] awaddr,
   input  wire logic       awvalid,
   output logic            awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0] wstrb,
   input  wire logic       wvalid,
   output logic            wready,
   output logic [1:0]      bresp,
   output logic            bvalid,
   input  wire logic       bready,
   input  wire logic [7:0] araddr,
   input  wire logic       arvalid,
   output logic            arready,
   output logic [31:0]     rdata,
   output logic [1:0]      rresp,
   output logic            rvalid,
   input  wire logic       rready,
   output logic            sys_reset_n,
   output logic            cpu_clk_en,
   output logic            periph_clk_en,
   output logic [2:0]      sys_clk_sel,
   output logic            primary_osc_en,
   output logic            frc_osc_en,
   output logic            low_power_rc_clock_en,
   output logic            irq
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic              aw_got;
      logic [7:0]        aw_addr;
      logic              w_got;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              fuses_taken;
      logic [2:0]        cur;
      logic [2:0]        nsrc;
      logic              lock;
      logic              cf;
      logic              oswen;
      logic              pll_ok;
      sw_t               sw;
      pm_t               pm;
      logic              wdt_sw_en;
      logic [2:0]        ps_div;
      logic [6:0]        ps_cnt;
      logic [NUM_EV-1:0] stat;
      logic [NUM_EV-1:0] mask;
      logic [2:0]        rcause;
      logic              irq;
      logic              por_hold;
      logic              ost_hold;
      logic              sys_rst_n;
      logic              cpu_en;
      logic              per_en;
      logic              pri_en;
      logic              frc_en;
      logic              low_power_rc_clock_en;
   } st_t;

   st_t st, n;

   timer_if power_up_delay_timer_if ();
   timer_if ost_if ();
   timer_if wdt_if ();
   timer_if fail_if ();

   logic wdt_on;
   logic fail_evt;
   logic wdt_evt;
   logic sw_ready;

   // ************************************************************
   // timers
   // ************************************************************
   interval_timer #(.LIMIT(TMR_W'(POWER_UP_DELAY_TIMER_CYCLES))) power_up_delay_timer_u (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .t        (power_up_delay_timer_if)
   );
   interval_timer #(.LIMIT(TMR_W'(OST_TICKS))) ost_u (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .t        (ost_if)
   );
   interval_timer #(.LIMIT(TMR_W'(WDT_TICKS))) wdt_u (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .t        (wdt_if)
   );
   interval_timer #(.LIMIT(TMR_W'(FAIL_CYCLES))) fail_u (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .t        (fail_if)
   );

   // timer controls: power-up delay runs only while the por hold is pending
   assign wdt_on       = wdt_fuse_on | st.wdt_sw_en;
   assign power_up_delay_timer_if.tick = 1'h1;
   assign power_up_delay_timer_if.clr  = !st.por_hold;
   assign ost_if.tick  = primary_osc_tick;
   assign ost_if.clr   = !st.ost_hold;
   assign wdt_if.tick  = low_power_rc_clock_tick;
   assign wdt_if.clr   = !wdt_on || wdt_clear || !st.sys_rst_n || wdt_if.expired ||
                         (st.pm == PM_RUN && sleep_req);
   assign fail_if.tick = 1'h1;
   assign fail_if.clr  = primary_osc_tick || !st.cur[SRC_PRI_BIT] || st.pm == PM_SLEEP ||
                         !st.fuses_taken;

   // event qualifiers
   assign fail_evt = fail_if.expired && st.cur[SRC_PRI_BIT] && st.pm != PM_SLEEP;
   assign wdt_evt  = wdt_on && wdt_if.expired;
   assign sw_ready = (!st.nsrc[SRC_PRI_BIT] || primary_ready) &&
                     (!st.nsrc[SRC_PLL_BIT] || pll_locked);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic              wr_go;
      logic [31:0]       wm;
      logic [31:0]       wd;
      logic              sw_req;
      logic [NUM_EV-1:0] ev;
      logic [6:0]        div_mask;
      logic              ps_tick;
      n        = st;
      wr_go    = st.aw_got && st.w_got && !st.bvalid;
      wm       = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
      wd       = st.w_data & wm;
      sw_req   = 1'h0;
      ev       = '0;
      div_mask = 7'((8'h01 << st.ps_div) - 8'h01);
      ps_tick  = (st.ps_cnt & div_mask) == 7'h00;

      // power-on source comes from the fuses, reserved codes fall back to fast rc
      if (!st.fuses_taken) begin
         n.fuses_taken = 1'h1;
         n.cur  = clock_select_fuses[SRC_RSV_BIT] ? SRC_FRC : clock_select_fuses;
         n.nsrc = n.cur;
      end

      // bus channels: address and data taken in either order
      if (awvalid && st.awready) begin
         n.aw_got  = 1'h1;
         n.aw_addr = awaddr;
      end
      if (wvalid && st.wready) begin
         n.w_got  = 1'h1;
         n.w_data = wdata;
         n.w_strb = wstrb;
      end
      if (st.bvalid && bready) begin
         n.bvalid = 1'h0;
      end

      // register writes
      if (wr_go) begin
         n.aw_got = 1'h0;
         n.w_got  = 1'h0;
         n.bvalid = 1'h1;
         n.bresp  = RESP_OKAY;
         case (st.aw_addr)
            ADDR_CCR: begin
               if (!st.lock && st.sw == SW_IDLE && st.fuses_taken) begin
                  if (st.w_strb[1]) begin
                     n.nsrc = st.w_data[NEW_LSB +: 3];
                  end
                  sw_req = st.w_strb[0] && st.w_data[OSWEN_BIT];
               end
               if (wd[LOCK_BIT]) begin
                  n.lock = 1'h1;
               end
               if (wd[CF_BIT]) begin
                  n.cf = 1'h0;
               end
            end
            ADDR_PWR: begin
               if (st.w_strb[0]) begin
                  n.wdt_sw_en = st.w_data[WDT_EN_BIT];
                  n.ps_div    = st.w_data[PS_LSB +: 3];
               end
            end
            ADDR_STAT: n.stat   = st.stat & ~wd[NUM_EV-1:0];
            ADDR_MASK: begin
               if (st.w_strb[0]) begin
                  n.mask = st.w_data[NUM_EV-1:0];
               end
            end
            ADDR_RST:  n.rcause = st.rcause & ~wd[2:0];
            default:   n.bresp  = RESP_SLVERR;
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready  = !n.w_got && !n.bvalid;

      // register reads
      if (st.rvalid && rready) begin
         n.rvalid  = 1'h0;
         n.arready = 1'h1;
      end
      if (arvalid && st.arready) begin
         n.arready = 1'h0;
         n.rvalid  = 1'h1;
         n.rresp   = RESP_OKAY;
         n.rdata   = 32'h00000000;
         case (araddr)
            ADDR_CCR: begin
               n.rdata[CUR_LSB +: 3] = st.cur;
               n.rdata[NEW_LSB +: 3] = st.nsrc;
               n.rdata[LOCK_BIT]     = st.lock;
               n.rdata[PLL_BIT]      = st.pll_ok;
               n.rdata[CF_BIT]       = st.cf;
               n.rdata[OSWEN_BIT]    = st.oswen;
            end
            ADDR_PWR: begin
               n.rdata[WDT_EN_BIT]  = wdt_on;
               n.rdata[PS_LSB +: 3] = st.ps_div;
            end
            ADDR_STAT: n.rdata[NUM_EV-1:0] = st.stat;
            ADDR_MASK: n.rdata[NUM_EV-1:0] = st.mask;
            ADDR_RST:  n.rdata[2:0]        = st.rcause;
            default:   n.rresp             = RESP_SLVERR;
         endcase
      end

      // clock switch sequencer
      unique case (st.sw)
         SW_IDLE: begin
            if (sw_req) begin
               if (!n.nsrc[SRC_RSV_BIT]) begin
                  n.oswen  = 1'h1;
                  n.cf     = 1'h0;
                  n.sw     = SW_WAIT;
               end
            end
         end
         SW_WAIT: begin
            if (sw_ready) begin
               n.cur   = st.nsrc;
               n.oswen = 1'h0;
               n.sw    = SW_IDLE;
               ev[EV_SWITCH] = 1'h1;
            end
         end
      endcase

      // failure: fall back to fast rc, overrides any switch under way
      if (fail_evt) begin
         n.cur  = SRC_FRC;
         n.cf   = 1'h1;
         n.oswen = 1'h0;
         n.sw   = SW_IDLE;
         ev[EV_FAIL] = 1'h1;
      end
      n.pll_ok = pll_locked && n.cur[SRC_PLL_BIT] && n.sw == SW_IDLE;

      // power modes
      unique case (st.pm)
         PM_RUN: begin
            if (st.sys_rst_n && sleep_req) begin
               n.pm = PM_SLEEP;
            end else if (st.sys_rst_n && idle_req) begin
               n.pm = PM_IDLE;
            end
         end
         PM_IDLE: begin
            if (irq_pending || wdt_evt) begin
               n.pm = PM_RUN;
            end
         end
         PM_SLEEP: begin
            if (irq_pending) begin
               n.pm = PM_RUN;
            end else if (wdt_evt) begin
               n.pm = PM_RUN;
               ev[EV_WAKE] = 1'h1;
            end
         end
      endcase

      // reset holding: por delay once, start-up delay on every reset while the primary oscillator is current
      if (st.por_hold && power_up_delay_timer_if.expired) begin
         n.por_hold = 1'h0;
      end
      if (st.ost_hold && st.fuses_taken && (ost_if.expired || !st.cur[SRC_PRI_BIT])) begin
         n.ost_hold = 1'h0;
      end
      if (ext_reset_req || (wdt_evt && st.pm == PM_RUN && st.sys_rst_n)) begin
         n.ost_hold = 1'h1;
         n.pm       = PM_RUN;
         n.lock     = 1'h0;
         n.sw       = SW_IDLE;
         n.oswen    = 1'h0;
         n.rcause   = n.rcause | (ext_reset_req ? RCAUSE_EXT : RCAUSE_WDT);
      end
      n.sys_rst_n = !n.por_hold && !n.ost_hold && !ext_reset_req;

      // status and interrupt, set wins over clear
      n.stat = n.stat | ev;
      n.irq  = |(n.stat & n.mask);

      // postscaler and clock gates
      n.ps_cnt  = st.ps_cnt + 7'h01;
      n.per_en  = n.pm != PM_SLEEP && n.sys_rst_n && ps_tick;
      n.cpu_en  = n.pm == PM_RUN && n.sys_rst_n && ps_tick;
      n.frc_en  = n.pm != PM_SLEEP;
      n.pri_en  = n.pm != PM_SLEEP && (n.cur[SRC_PRI_BIT] || n.nsrc[SRC_PRI_BIT]);
      n.low_power_rc_clock_en = wdt_fuse_on || n.wdt_sw_en;
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st          <= '0;
         st.awready  <= 1'h1;
         st.wready   <= 1'h1;
         st.arready  <= 1'h1;
         st.por_hold <= 1'h1;
         st.ost_hold <= 1'h1;
         st.rcause   <= RCAUSE_POR;
      end else begin
         st <= n;
      end
   end

   // outputs straight from the state flops
   assign awready        = st.awready;
   assign wready         = st.wready;
   assign bvalid         = st.bvalid;
   assign bresp          = st.bresp;
   assign arready        = st.arready;
   assign rvalid         = st.rvalid;
   assign rdata          = st.rdata;
   assign rresp          = st.rresp;
   assign sys_reset_n    = st.sys_rst_n;
   assign cpu_clk_en     = st.cpu_en;
   assign periph_clk_en  = st.per_en;
   assign sys_clk_sel    = st.cur;
   assign primary_osc_en = st.pri_en;
   assign frc_osc_en     = st.frc_en;
   assign low_power_rc_clock_en        = st.low_power_rc_clock_en;
   assign irq            = st.irq;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   lock_sticky_a: assert property (st.lock && !ext_reset_req && !wdt_evt
                                   |=> st.lock)
      else $error("config lock dropped without reset");
   fail_frc_a: assert property (fail_evt |=> sys_clk_sel == SRC_FRC && st.cf && !st.oswen)
      else $error("failure did not fall back to fast rc");
   switch_load_a: assert property (st.sw == SW_WAIT && sw_ready && !fail_evt
                                   |=> st.cur == $past(st.nsrc) && st.sw == SW_IDLE)
      else $error("current source not loaded on switch completion");
   reserved_src_a: assert property (st.fuses_taken |-> !st.cur[SRC_RSV_BIT])
      else $error("reserved clock source became current");
   sleep_clk_a: assert property (st.pm == PM_SLEEP |-> !periph_clk_en && !cpu_clk_en &&
                                 (low_power_rc_clock_en || !st.wdt_sw_en))
      else $error("clock gating wrong in sleep");
   idle_clk_a: assert property (st.pm == PM_IDLE |-> !cpu_clk_en && frc_osc_en)
      else $error("clock gating wrong in idle");
   sleep_wake_a: assert property (st.pm == PM_SLEEP && (irq_pending || wdt_evt)
                                  |=> st.pm == PM_RUN)
      else $error("sleep not left on wake cause");
   reset_release_a: assert property (sys_reset_n |-> !st.por_hold && !st.ost_hold)
      else $error("reset released before both timers");
   por_once_a: assert property (!st.por_hold |=> !st.por_hold)
      else $error("power-up delay applied again");
   wdt_reset_a: assert property (wdt_evt && st.pm == PM_RUN && st.sys_rst_n
                                 |=> !sys_reset_n && st.ost_hold && (st.rcause & RCAUSE_WDT) != 3'h0)
      else $error("watchdog timeout did not reset");

   switch_done_c: cover property (st.sw == SW_WAIT ##1 st.sw == SW_IDLE && !st.cf);
   fail_seen_c: cover property (fail_evt);
   wdt_wake_c: cover property (st.pm == PM_SLEEP && wdt_evt);
   idle_exit_c: cover property (st.pm == PM_IDLE ##1 st.pm == PM_RUN);

endmodule
`default_nettype wire

// File: clk_sup_pkg.sv
// constants and types shared by the clock, reset and power supervisor
package clk_sup_pkg;

   // ************************************************************
   // clock rate and timing
   // ************************************************************
   localparam int unsigned CLK_MHZ       = 50;
   localparam int unsigned POWER_UP_DELAY_TIMER_TIME_US  = 64;    // power-up settle delay
   localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES   = POWER_UP_DELAY_TIMER_TIME_US * CLK_MHZ;
   localparam int unsigned OST_TICKS     = 1024;  // primary oscillator edges
   localparam int unsigned WDT_TICKS     = 512;   // watchdog oscillator ticks
   localparam int unsigned FAIL_TIME_NS  = 2000;  // longest gap between primary edges
   localparam int unsigned FAIL_CYCLES   = (FAIL_TIME_NS * CLK_MHZ) / 1000;
   localparam int unsigned TMR_W         = 24;

   // ************************************************************
   // clock source codes
   // ************************************************************
   localparam logic [2:0] SRC_FRC     = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI     = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL = 3'h3;
   localparam int unsigned SRC_PLL_BIT = 0;  // code uses the pll
   localparam int unsigned SRC_PRI_BIT = 1;  // code uses the primary oscillator
   localparam int unsigned SRC_RSV_BIT = 2;  // set in every reserved code

   // ************************************************************
   // register offsets and fields
   // ************************************************************
   localparam logic [7:0] ADDR_CCR  = 8'h00;  // clock_control_register
   localparam logic [7:0] ADDR_PWR  = 8'h04;  // watchdog enable and postscaler
   localparam logic [7:0] ADDR_STAT = 8'h08;  // sticky event status
   localparam logic [7:0] ADDR_MASK = 8'h0c;  // interrupt mask
   localparam logic [7:0] ADDR_RST  = 8'h10;  // reset cause
   localparam int unsigned CUR_LSB   = 12;
   localparam int unsigned NEW_LSB   = 8;
   localparam int unsigned LOCK_BIT  = 7;
   localparam int unsigned PLL_BIT   = 5;
   localparam int unsigned CF_BIT    = 3;
   localparam int unsigned OSWEN_BIT = 0;
   localparam int unsigned WDT_EN_BIT = 0;
   localparam int unsigned PS_LSB    = 1;
   localparam int unsigned EV_FAIL   = 0;
   localparam int unsigned EV_SWITCH = 1;
   localparam int unsigned EV_WAKE   = 2;
   localparam int unsigned NUM_EV    = 3;
   localparam logic [2:0] RCAUSE_POR = 3'h1;  // bit0 por, bit1 external, bit2 watchdog
   localparam logic [2:0] RCAUSE_EXT = 3'h2;
   localparam logic [2:0] RCAUSE_WDT = 3'h4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // state machines
   // ************************************************************
   typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} pm_t;
   typedef enum logic {SW_IDLE, SW_WAIT} sw_t;

endpackage

// File: timer_if.sv
// link between the supervisor and one of its interval timers
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
   logic clr;
   logic tick;
   logic expired;
   modport ctrl (output clr, output tick, input expired);
   modport tmr  (input clr, input tick, output expired);
endinterface
`default_nettype wire

// File: interval_timer.sv
// interval timer counting tick enables up to a fixed limit
`timescale 1ns/1ns
`default_nettype none
module interval_timer
   import clk_sup_pkg::*;
#(
   parameter logic [TMR_W-1:0] LIMIT = 24'h000001
) (
   input  wire logic core_clk,
   input  wire logic reset_n,
   timer_if.tmr      t
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic             expired;
   } tmr_t;

   tmr_t st, n;

   // count ticks, flag the limit, restart on clear
   always_comb begin
      n = st;
      if (t.clr) begin
         n = '0;
      end else if (t.tick && !st.expired) begin
         n.cnt     = st.cnt + 24'h000001;
         n.expired = (n.cnt == LIMIT);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= n;
      end
   end

   assign t.expired = st.expired;
endmodule
`default_nettype wire

// File: clock_reset_power_supervisor_test.sv
// self-checking bench for the clock, reset and power supervisor
`timescale 1ns/1ns
`default_nettype none
module clock_reset_power_supervisor_test
   import clk_sup_pkg::*;
();
   logic        core_clk, reset_n, wdt_fuse_on, ext_reset_req, primary_osc_tick, primary_ready;
   logic        pll_locked, low_power_rc_clock_tick, wdt_clear, sleep_req, idle_req, irq_pending, pri_on;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic        sys_reset_n, cpu_clk_en, periph_clk_en, primary_osc_en, frc_osc_en, low_power_rc_clock_en, irq;
   logic [2:0]  clock_select_fuses, sys_clk_sel;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   int          failures, checks, cyc, np, nc, t0;

   clock_reset_power_supervisor i_dut (.core_clk, .reset_n, .clock_select_fuses, .wdt_fuse_on,
      .ext_reset_req, .primary_osc_tick, .primary_ready, .pll_locked, .low_power_rc_clock_tick, .wdt_clear,
      .sleep_req, .idle_req, .irq_pending, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .sys_reset_n, .cpu_clk_en, .periph_clk_en, .sys_clk_sel,
      .primary_osc_en, .frc_osc_en, .low_power_rc_clock_en, .irq);

   // ************************************************************
   // clock, oscillator ticks and hang guard
   // ************************************************************
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end

   // watchdog rc ticks every 4 cycles, primary ticks every 2 while running
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      low_power_rc_clock_tick <= (cyc[1:0] == 2'h0);
      primary_osc_tick <= pri_on & cyc[0];
      if (cyc == 20000) begin
         failures++;
         stop_test;
      end
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: got %h, want %h", $time, s, e);
      end
   endtask

   task stop_test;
      if (failures == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // write: both channels offered together, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge core_clk); while (!bvalid);
      rs = bresp;
      bready <= 1'h0;
      @(posedge core_clk);
   endtask

   task rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge core_clk); while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      @(posedge core_clk);
   endtask

   // counts clock enable pulses over n cycles
   task cnt(input int n);
      np = 0;
      nc = 0;
      repeat (n) begin
         @(posedge core_clk);
         np += periph_clk_en;
         nc += cpu_clk_en;
      end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task t_start;
      repeat (3100) @(posedge core_clk);
      chk(sys_reset_n, 0);
      while (sys_reset_n !== 1'h1) @(posedge core_clk);
      chk(cyc < 3400, 1);
      chk(sys_clk_sel, SRC_FRC_PLL);
      rdr(ADDR_RST);
      chk(rd, RCAUSE_POR);
      rdr(ADDR_CCR);
      chk({rd[14:12], rd[5]}, {SRC_FRC_PLL, 1'h1});
   endtask

   task t_switch;
      wr(ADDR_MASK, 32'h7);
      chk(rs, RESP_OKAY);
      wr(ADDR_CCR, {SRC_PRI, 8'h01});
      repeat (4) @(posedge core_clk);
      chk(sys_clk_sel, SRC_PRI);
      chk(irq, 1);
      chk(primary_osc_en, 1);
      rdr(ADDR_CCR);
      chk(rd[14:8], {SRC_PRI, 1'h0, SRC_PRI});
      wr(ADDR_STAT, 32'h2);
      chk(irq, 0);
      wr(ADDR_CCR, {3'h5, 8'h01});
      repeat (4) @(posedge core_clk);
      chk(sys_clk_sel, SRC_PRI);
   endtask

   task t_fail;
      pri_on <= 1'h0;
      repeat (FAIL_CYCLES + 10) @(posedge core_clk);
      chk(sys_clk_sel, SRC_FRC);
      rdr(ADDR_CCR);
      chk({rd[3], irq}, 2'h3);
      wr(ADDR_CCR, 32'h8);
      wr(ADDR_STAT, 32'h1);
      rdr(ADDR_CCR);
      chk({rd[3], irq}, 0);
      wr(ADDR_CCR, 32'h80);
      wr(ADDR_CCR, {SRC_FRC_PLL, 8'h01});
      wr(ADDR_CCR, 32'h0);
      rdr(ADDR_CCR);
      chk(rd[14:7], {SRC_FRC, 1'h0, SRC_FRC, 1'h1});
   endtask

   task t_power;
      wr(ADDR_PWR, 32'h4);
      cnt(16);
      chk(np, 4);
      wr(ADDR_PWR, 32'h0);
      idle_req <= 1'h1;
      @(posedge core_clk);
      idle_req <= 1'h0;
      repeat (2) @(posedge core_clk);
      cnt(8);
      chk({nc[3:0], np[3:0], frc_osc_en}, {4'h0, 4'h8, 1'h1});
      irq_pending <= 1'h1;
      repeat (3) @(posedge core_clk);
      irq_pending <= 1'h0;
      cnt(4);
      chk(nc, 4);
      wr(ADDR_PWR, 32'h1);
      chk(low_power_rc_clock_en, 1);
      sleep_req <= 1'h1;
      t0 = cyc;
      @(posedge core_clk);
      sleep_req <= 1'h0;
      repeat (2) @(posedge core_clk);
      cnt(8);
      chk({np[3:0], frc_osc_en, low_power_rc_clock_en}, 6'h1);
      // restart the watchdog mid-sleep, the wake is timed from this clear
      wdt_clear <= 1'h1;
      t0 = cyc;
      @(posedge core_clk);
      wdt_clear <= 1'h0;
      while (periph_clk_en !== 1'h1) @(posedge core_clk);
      chk((cyc - t0 + 8) / 32, 64);
      rdr(ADDR_STAT);
      chk(rd[2], 1);
      wr(ADDR_STAT, 32'h4);
      // left running in run mode, the next timeout resets the chip
      while (sys_reset_n !== 1'h0) @(posedge core_clk);
      rdr(ADDR_RST);
      chk(rd[2], 1);
      wr(ADDR_PWR, 32'h0);
   endtask

   task t_ext;
      rdr(8'h20);
      chk(rs, RESP_SLVERR);
      wr(8'h20, 32'h0);
      chk(rs, RESP_SLVERR);
      ext_reset_req <= 1'h1;
      repeat (3) @(posedge core_clk);
      chk(sys_reset_n, 0);
      ext_reset_req <= 1'h0;
      t0 = cyc;
      while (sys_reset_n !== 1'h1) @(posedge core_clk);
      chk(cyc - t0 < 100, 1);
      rdr(ADDR_RST);
      chk(rd[1], 1);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {reset_n, wdt_fuse_on, ext_reset_req, wdt_clear} = '0;
      {sleep_req, idle_req, irq_pending, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      primary_ready = 1'h1;
      pll_locked = 1'h1;
      pri_on = 1'h1;
      clock_select_fuses = SRC_FRC_PLL;
      failures = 0;
      checks = 0;
      cyc = 0;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'h1;
      t_start;
      t_switch;
      t_fail;
      t_power;
      t_ext;
      stop_test;
   end
endmodule
`default_nettype wire
